/* rtl/panel_ctrl.sv */
/*
 Front-panel controller of the hand-held programmer: mode selector,
 address/data display, status lamps, logic lamps, logic keys and the
 two power-flow combine operations used by the logic solver.
 Assumes key presses arrive as one-cycle strobes synchronous to ref_clk,
 and that the scan engine marks each scan boundary with scan_end.
*/
`default_nettype none
`include "panel_cfg.svh"

// What this block does
// RULE_01 - Left position runs program, outputs enabled
// RULE_02 - Run mode rejects program alterations
// RULE_03 - Centre position edits, no solving
// RULE_04 - Right position routes tape, no solving
// RULE_05 - Power-up runs unless programmer selects otherwise
// RULE_06 - Addresses decimal, dots and address lamp
// RULE_07 - Address runs 0000 up to 1723
// RULE_08 - Reference lamp follows selected reference in run
// RULE_09 - Run lamp only while solving
// RULE_10 - Battery lamp lit on low voltage
// RULE_11 - Supply lamp lit while DC present
// RULE_12 - Fault lamp lit on hardware fault
// RULE_13 - Programmer lamps mirror CPU lamps
// RULE_14 - Logic lamps show stored or pending type
// RULE_15 - Shift latches until enter or clear
// RULE_16 - Data lamp with BCD register contents
// RULE_17 - Register lamp on address, monitor toggles
// RULE_18 - Monitor shows sixteen I/O states
// RULE_19 - Keys select functions; dot only timer tenths
// RULE_20 - Series combine needs both conducting
// RULE_21 - Parallel combine needs either conducting
// RULE_22 - Mode change applied at scan boundary
module panel_ctrl
   import panel_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // Selector and attachment.
   input wire logic programmer_present,
   input wire logic [2:0] selector,
   input wire logic scan_end,
   // Keys.
   input wire logic key_strobe,
   input wire logic [`KEY_W-1:0] key_code,
   input wire logic timer_preset_entry,
   // CPU status sources.
   input wire logic ref_energised,
   input wire logic battery_low,
   input wire logic dc_supply_ok,
   input wire logic hw_fault,
   // Memory and monitor data.
   input wire logic [`ADDR_W-1:0] program_last_addr,
   input wire logic [`LOGIC_LAMPS-1:0] stored_type,
   input wire logic [`LOGIC_LAMPS-1:0] pending_type,
   input wire logic editing,
   input wire logic monitor_active,
   input wire logic reg_monitor,
   input wire logic [`LOGIC_LAMPS-1:0] io_states,
   input wire logic [`DIGITS*`DIGIT_W-1:0] reg_addr_bcd,
   input wire logic [`DIGITS*`DIGIT_W-1:0] reg_data_bcd,
   input wire logic addr_next,
   input wire logic addr_prev,
   // Power-flow combine operands.
   input wire logic flow_a,
   input wire logic flow_b,
   // Controller state.
   output logic solving,
   output logic outputs_enabled,
   output logic edit_allowed,
   output logic tape_route,
   output logic edit_rejected,
   output logic [`KEY_W-1:0] digit_out,
   output logic digit_valid,
   output logic program_edit_mode,
   // Display.
   output logic [`DIGITS*`DIGIT_W-1:0] display_digits,
   output logic [`DIGITS-1:0] display_dots,
   output logic [`ADDR_W-1:0] cur_addr,
   // Lamps.
   output logic addr_lamp,
   output logic upper_label_select,
   output logic data_lamp,
   output logic reg_lamp,
   output logic ref_state_lamp,
   output logic run_lamp,
   output logic low_backup_cell_lamp,
   output logic supply_good_lamp,
   output logic fault_lamp,
   output logic [`LOGIC_LAMPS-1:0] logic_lamps,
   // Combine results.
   output logic series_flow,
   output logic parallel_flow
);

   mode_e mode, next_mode;
   logic started, next_started;
   logic [`ADDR_W-1:0] next_cur_addr;
   logic next_shift;
   show_e show, next_show;
   logic next_edit_rejected;
   logic next_digit_valid;
   logic [`KEY_W-1:0] next_digit_out;
   logic [`DIGITS*`DIGIT_W-1:0] addr_bcd;
   logic [`DIGITS*`DIGIT_W-1:0] next_display_digits;
   logic [`DIGITS-1:0] next_display_dots;
   logic next_addr_lamp, next_data_lamp, next_reg_lamp;
   logic next_ref_state_lamp, next_run_lamp, next_low_backup_cell_lamp, next_supply, next_fault;
   logic [`LOGIC_LAMPS-1:0] next_logic_lamps;
   logic next_series, next_parallel;
   mode_e sel_mode;

   // Decode a selector reading; anything unclear falls back to run.
   function automatic mode_e decode_sel(input logic present, input logic [2:0] s);
      if (present && s == mode_edit) begin
         return mode_edit;
      end
      if (present && s == mode_tape) begin
         return mode_tape;
      end
      return mode_run;
   endfunction

   // Numeric key test for keys 0 to 9, used for digit entry; the dot key is tested separately.
   function automatic logic is_digit(input logic [`KEY_W-1:0] k);
      return k <= `KEY_DIGIT_MAX;
   endfunction

   assign sel_mode = decode_sel(programmer_present, selector);

   bin_to_bcd u_addr_bcd (
      .bin(cur_addr),
      .bcd(addr_bcd)
   );

   // Mode register. The first mode after reset is taken from the selector
   // on the first clocked cycle, since a reset flop may not load a port.
   always_comb begin
      next_mode = mode;
      next_started = 1'b1;
      // RULE_05 power-up mode
      if (!started) begin
         next_mode = sel_mode;
      // RULE_22 scan boundary switch
      end else if (scan_end) begin
         next_mode = sel_mode;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode <= mode_run;
         started <= 1'b0;
      end else begin
         mode <= next_mode;
         started <= next_started;
      end
   end

   // Mode decode; solving is held off until the first mode is taken.
   always_comb begin
      // RULE_01 run executes
      solving = started && (mode == mode_run);
      outputs_enabled = solving;
      // RULE_03 edit mode
      edit_allowed = started && (mode == mode_edit);
      program_edit_mode = edit_allowed;
      // RULE_04 tape routing
      tape_route = started && (mode == mode_tape);
   end

   // Key handling: shift latch, digits, address stepping and monitor toggle.
   always_comb begin
      next_shift = upper_label_select;
      next_edit_rejected = 1'b0;
      next_digit_valid = 1'b0;
      next_digit_out = digit_out;
      next_cur_addr = cur_addr;
      next_show = show;
      if (!reg_monitor) begin
         next_show = show_addr;
      end else if (show == show_addr || show == show_value) begin
         next_show = show_reg_addr;
      end
      if (key_strobe) begin
         // RULE_15 shift latch
         if (key_code == `KEY_SHIFT) begin
            next_shift = 1'b1;
         end else if (key_code == `KEY_ENTER || key_code == `KEY_CLEAR) begin
            next_shift = 1'b0;
            // RULE_02 reject in run
            if (key_code == `KEY_ENTER && mode == mode_run) begin
               next_edit_rejected = 1'b1;
            end
         // RULE_17 monitor toggle
         end else if (key_code == `KEY_MON && reg_monitor) begin
            next_show = (show == show_reg_addr) ? show_reg_data : show_reg_addr;
         // RULE_19 digit and dot
         end else if (upper_label_select && (is_digit(key_code) ||
                      (key_code == `KEY_DOT && timer_preset_entry))) begin
            next_digit_valid = 1'b1;
            next_digit_out = key_code;
         end else if (!upper_label_select && key_code <= `KEY_DOT && mode == mode_run) begin
            // RULE_02 reject in run
            next_edit_rejected = 1'b1;
         end
      end
      // RULE_07 address bounds
      if (addr_next && cur_addr < program_last_addr && cur_addr < `ADDR_LAST) begin
         next_cur_addr = cur_addr + 11'h001;
      end else if (addr_prev && cur_addr > `ADDR_FIRST) begin
         next_cur_addr = cur_addr - 11'h001;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         upper_label_select <= 1'b0;
         edit_rejected <= 1'b0;
         digit_valid <= 1'b0;
         digit_out <= 4'h0;
         cur_addr <= `ADDR_FIRST;
         show <= show_addr;
      end else begin
         upper_label_select <= next_shift;
         edit_rejected <= next_edit_rejected;
         digit_valid <= next_digit_valid;
         digit_out <= next_digit_out;
         cur_addr <= next_cur_addr;
         show <= next_show;
      end
   end

   // Display and lamps, registered so the panel never sees glitches.
   always_comb begin
      next_display_digits = addr_bcd;
      next_display_dots = '0;
      next_addr_lamp = 1'b0;
      next_reg_lamp = 1'b0;
      next_data_lamp = 1'b0;
      unique case (show)
         // RULE_06 address dots
         show_addr: begin
            next_display_dots = '1;
            next_addr_lamp = 1'b1;
         end
         show_value: begin
            next_display_digits = addr_bcd;
         end
         show_reg_addr: begin
            next_display_digits = reg_addr_bcd;
            next_reg_lamp = 1'b1;
         end
         // RULE_16 register contents
         show_reg_data: begin
            next_display_digits = reg_data_bcd;
            next_data_lamp = 1'b1;
         end
      endcase
      // RULE_08 reference lamp
      next_ref_state_lamp = solving && ref_energised;
      // RULE_09 run lamp
      next_run_lamp = solving;
      // RULE_13 mirror CPU lamps
      next_low_backup_cell_lamp = battery_low;
      next_supply = dc_supply_ok;
      next_fault = hw_fault;
      // RULE_18 monitor lamps
      if (monitor_active) begin
         next_logic_lamps = io_states;
      // RULE_14 logic type lamps
      end else if (editing) begin
         next_logic_lamps = pending_type;
      end else begin
         next_logic_lamps = stored_type;
      end
      // RULE_20 series combine
      next_series = flow_a & flow_b;
      // RULE_21 parallel combine
      next_parallel = flow_a | flow_b;
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         display_digits <= '0;
         display_dots <= '0;
         addr_lamp <= 1'b0;
         reg_lamp <= 1'b0;
         data_lamp <= 1'b0;
         ref_state_lamp <= 1'b0;
         run_lamp <= 1'b0;
         low_backup_cell_lamp <= 1'b0;
         supply_good_lamp <= 1'b0;
         fault_lamp <= 1'b0;
         logic_lamps <= '0;
         series_flow <= 1'b0;
         parallel_flow <= 1'b0;
      end else begin
         display_digits <= next_display_digits;
         display_dots <= next_display_dots;
         addr_lamp <= next_addr_lamp;
         reg_lamp <= next_reg_lamp;
         data_lamp <= next_data_lamp;
         ref_state_lamp <= next_ref_state_lamp;
         run_lamp <= next_run_lamp;
         // RULE_10 battery lamp
         low_backup_cell_lamp <= next_low_backup_cell_lamp;
         // RULE_11 supply lamp
         supply_good_lamp <= next_supply;
         // RULE_12 fault lamp
         fault_lamp <= next_fault;
         logic_lamps <= next_logic_lamps;
         series_flow <= next_series;
         parallel_flow <= next_parallel;
      end
   end

   property p_run_outputs;
      @(posedge ref_clk) disable iff (!arst_n)
      outputs_enabled |-> (mode == mode_run) && solving;
   endproperty
   a_run_outputs: assert property (p_run_outputs) else $error("outputs on outside run"); // RULE_01

   property p_reject;
      @(posedge ref_clk) disable iff (!arst_n)
      (key_strobe && key_code == `KEY_ENTER && mode == mode_run) |=> edit_rejected;
   endproperty
   a_reject: assert property (p_reject) else $error("run edit not rejected"); // RULE_02

   property p_no_solve;
      @(posedge ref_clk) disable iff (!arst_n)
      (edit_allowed || tape_route) |-> !solving;
   endproperty
   a_no_solve: assert property (p_no_solve) else $error("solving outside run"); // RULE_03

   property p_mode_hold;
      @(posedge ref_clk) disable iff (!arst_n)
      (started && !scan_end) |=> $stable(mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved mid scan"); // RULE_22

   property p_addr_lamp;
      @(posedge ref_clk) disable iff (!arst_n)
      (show == show_addr) |=> addr_lamp && display_dots == '1;
   endproperty
   a_addr_lamp: assert property (p_addr_lamp) else $error("address lamp or dots missing"); // RULE_06

   property p_addr_max;
      @(posedge ref_clk) disable iff (!arst_n)
      cur_addr <= `ADDR_LAST;
   endproperty
   a_addr_max: assert property (p_addr_max) else $error("address beyond last"); // RULE_07

   property p_run_lamp;
      @(posedge ref_clk) disable iff (!arst_n)
      $rose(solving) |=> run_lamp;
   endproperty
   a_run_lamp: assert property (p_run_lamp) else $error("run lamp late"); // RULE_09

   property p_mirror;
      @(posedge ref_clk) disable iff (!arst_n)
      hw_fault |=> fault_lamp;
   endproperty
   a_mirror: assert property (p_mirror) else $error("fault lamp not mirrored"); // RULE_13

   property p_shift;
      @(posedge ref_clk) disable iff (!arst_n)
      (key_strobe && key_code == `KEY_SHIFT) |=> upper_label_select;
   endproperty
   a_shift: assert property (p_shift) else $error("shift not latched"); // RULE_15

   property p_series;
      @(posedge ref_clk) disable iff (!arst_n)
      (flow_a && !flow_b) |=> !series_flow && parallel_flow;
   endproperty
   a_series: assert property (p_series) else $error("combine wrong"); // RULE_20

endmodule
`default_nettype wire

/* pkg/panel_cfg.svh */
/*
 Constants for the programmer front-panel controller: address limits,
 key codes, the logic lamp count and display widths.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef PANEL_CFG_SVH
`define PANEL_CFG_SVH

`define ADDR_W 11
`define ADDR_LAST 11'h6bb
`define ADDR_FIRST 11'h000
`define KEY_W 4
`define KEY_AND 4'h0
`define KEY_OR 4'h1
`define KEY_SHIFT 4'hc
`define KEY_ENTER 4'hd
`define KEY_CLEAR 4'he
`define KEY_MON 4'hf
`define KEY_DOT 4'hb
`define KEY_DIGIT_MAX 4'h9
`define LOGIC_LAMPS 16
`define DIGITS 4
`define DIGIT_W 4
`define BCD_TEN 4'ha

`endif

/* pkg/panel_pkg.sv */
/*
 Types shared by the programmer front-panel controller.
 Assumes the constants header is on the include path.
*/
`default_nettype none
`include "panel_cfg.svh"
package panel_pkg;
   // Mode selector positions, one-hot.
   typedef enum logic [2:0] {
      mode_run = 3'b001,
      mode_edit = 3'b010,
      mode_tape = 3'b100
   } mode_e;
   // What the four-digit display is showing, one-hot.
   typedef enum logic [3:0] {
      show_addr = 4'b0001,
      show_value = 4'b0010,
      show_reg_addr = 4'b0100,
      show_reg_data = 4'b1000
   } show_e;
endpackage
`default_nettype wire

/* rtl/bin_to_bcd.sv */
/*
 Converts an 11-bit binary program address to four BCD digits
 by shift-and-add-three, purely combinational.
 Assumes the input never exceeds 9999.
*/
`default_nettype none
`include "panel_cfg.svh"
module bin_to_bcd (
   // Binary in.
   input wire logic [`ADDR_W-1:0] bin,
   // Four BCD digits out, most significant first.
   output logic [`DIGITS*`DIGIT_W-1:0] bcd
);
   // Classic double-dabble; the loop bounds are fixed so it unrolls.
   always_comb begin
      logic [`DIGITS*`DIGIT_W-1:0] acc;
      acc = '0;
      for (int i = `ADDR_W - 1; i >= 0; i--) begin
         for (int d = 0; d < `DIGITS; d++) begin
            if (acc[d*`DIGIT_W +: `DIGIT_W] > 4'h4) begin
               acc[d*`DIGIT_W +: `DIGIT_W] = acc[d*`DIGIT_W +: `DIGIT_W] + 4'h3;
            end
         end
         acc = {acc[`DIGITS*`DIGIT_W-2:0], bin[i]};
      end
      bcd = acc;
   end
endmodule
`default_nettype wire

/* tb/scan_engine.sv */
/*
 Model of the controller scan engine that sits beside the panel logic.
 Assumes the bench sets the gap, in cycles, between scan boundaries.
*/
`default_nettype none
module scan_engine (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic arst_n,
   // Idle cycles between boundaries.
   input wire logic [3:0] gap,
   // Boundary strobe.
   output logic scan_end
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   // A long gap models a slow scan, so mode changes must wait longer.
   // boundary pulse
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 4'h0;
         scan_end <= 1'b0;
      end else begin
         scan_end <= (cnt >= gap);
         cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
 Self-checking bench for the programmer front-panel controller.
 Assumes the constants header is on the include path and the scan model.
*/
`default_nettype none
`include "panel_cfg.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, arst_n = 1'b0, programmer_present = 1'b1, key_strobe = 1'b0;
   logic timer_preset_entry = 1'b0, ref_energised = 1'b0, battery_low = 1'b0, hw_fault = 1'b0;
   logic dc_supply_ok = 1'b0, editing = 1'b0, monitor_active = 1'b0, reg_monitor = 1'b0;
   logic addr_next = 1'b0, addr_prev = 1'b0, flow_a = 1'b0, flow_b = 1'b0, scan_end;
   logic [2:0] selector = 3'b010;
   logic [3:0] key_code = 4'h0, gap = 4'h3, digit_out;
   logic [10:0] program_last_addr = 11'h000, cur_addr;
   logic [15:0] stored_type = 16'h0, pending_type = 16'h0, io_states = 16'h0;
   logic [15:0] reg_addr_bcd = 16'h0, reg_data_bcd = 16'h0, display_digits, logic_lamps;
   logic [3:0] display_dots;
   logic solving, outputs_enabled, edit_allowed, tape_route, edit_rejected, digit_valid;
   logic program_edit_mode, addr_lamp, upper_label_select, data_lamp, reg_lamp;
   logic ref_state_lamp, run_lamp, low_backup_cell_lamp, supply_good_lamp, fault_lamp;
   logic series_flow, parallel_flow;
   logic [31:0] seed = 32'h5874d075;
   logic [4:0] q[$];
   int err_count = 0, check_count = 0, cyc = 0;

   panel_ctrl u_dut (.ref_clk, .arst_n, .programmer_present, .selector, .scan_end,
      .key_strobe, .key_code, .timer_preset_entry, .ref_energised, .battery_low,
      .dc_supply_ok, .hw_fault, .program_last_addr, .stored_type, .pending_type, .editing,
      .monitor_active, .reg_monitor, .io_states, .reg_addr_bcd, .reg_data_bcd, .addr_next,
      .addr_prev, .flow_a, .flow_b, .solving, .outputs_enabled, .edit_allowed, .tape_route,
      .edit_rejected, .digit_out, .digit_valid, .program_edit_mode, .display_digits,
      .display_dots, .cur_addr, .addr_lamp, .upper_label_select, .data_lamp, .reg_lamp,
      .ref_state_lamp, .run_lamp, .low_backup_cell_lamp, .supply_good_lamp, .fault_lamp,
      .logic_lamps, .series_flow, .parallel_flow);
   scan_engine u_scan (.ref_clk, .arst_n, .gap, .scan_end);

   // Clock at 200 MHz.
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // Compare and count; unknowns never match.
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h seen %h", n, e, s);
      end
   endtask

   task summarize;
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Wait n edges, then sample at the falling edge where outputs are settled.
   task wt(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask

   task key(input logic [3:0] c);
      @(posedge ref_clk);
      key_strobe <= 1'b1;
      key_code <= c;
      @(posedge ref_clk);
      key_strobe <= 1'b0;
   endtask

   task step(input logic up, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         addr_next <= up;
         addr_prev <= !up;
         @(posedge ref_clk);
         addr_next <= 1'b0;
         addr_prev <= 1'b0;
      end
   endtask

   // Returns at the edge where a scan boundary is sampled.
   task sc;
      repeat (40) begin
         @(posedge ref_clk);
         if (scan_end === 1'b1) break;
      end
   endtask

   // Random status levels; lamps follow them a cycle later.
   task lamps(input logic run);
      logic [31:0] r;
      for (int i = 0; i < 8; i++) begin
         r = xs();
         @(posedge ref_clk);
         {ref_energised, hw_fault, dc_supply_ok, battery_low, flow_b, flow_a} <= r[5:0];
         {monitor_active, editing} <= r[7:6];
         stored_type <= r[23:8];
         pending_type <= r[31:16];
         io_states <= r[15:0] ^ 16'h5a5a;
         wt(2);
         chk("series", series_flow, r[0] & r[1]);
         chk("parallel", parallel_flow, r[0] | r[1]);
         chk("battery", low_backup_cell_lamp, r[2]);
         chk("supply", supply_good_lamp, r[3]);
         chk("fault", fault_lamp, r[4]);
         chk("run_lamp", run_lamp, run);
         chk("ref_lamp", ref_state_lamp, run & r[5]);
         chk("logic", logic_lamps, r[7] ? r[15:0] ^ 16'h5a5a : r[6] ? r[31:16] : r[23:8]);
      end
      @(posedge ref_clk);
      {editing, monitor_active} <= 2'b00;
   endtask

   // Each digit or refusal pulse takes the oldest note off the queue.
   // key results
   always @(negedge ref_clk) begin
      if (digit_valid === 1'b1 || edit_rejected === 1'b1) begin
         if (q.size() == 0) chk("unexpected", {edit_rejected, digit_valid}, 16'h0);
         else chk("key", {edit_rejected, digit_valid ? digit_out : 4'h0}, q.pop_front());
      end
   end

   // Cut a hang short well past the expected run length.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         summarize();
      end
   end

   // Main sequence: edit keys, lamps, address walk, monitor, mode changes, reset.
   initial begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      wt(1);
      chk("edit", edit_allowed, 1'b1);
      chk("solving", solving, 1'b0);
      chk("pgm", program_edit_mode, 1'b1);
      key(4'hc);
      @(negedge ref_clk);
      chk("shift", upper_label_select, 1'b1);
      for (int d = 0; d < 10; d++) begin
         q.push_back({1'b0, 4'(d)});
         key(4'(d));
      end
      key(4'hb);
      @(posedge ref_clk);
      timer_preset_entry <= 1'b1;
      q.push_back({1'b0, 4'hb});
      key(4'hb);
      key(4'hd);
      @(negedge ref_clk);
      chk("shift", upper_label_select, 1'b0);
      key(4'h5);
      lamps(1'b0);
      program_last_addr <= 11'h00c;
      step(1'b1, 20);
      wt(1);
      chk("addr", cur_addr, 11'h00c);
      chk("disp", display_digits, 16'h0012);
      chk("dots", display_dots, 4'hf);
      chk("adr_lamp", addr_lamp, 1'b1);
      @(posedge ref_clk);
      program_last_addr <= 11'h7ff;
      step(1'b1, 1730);
      wt(1);
      chk("addr", cur_addr, 11'h6bb);
      chk("disp", display_digits, 16'h1723);
      step(1'b0, 1730);
      wt(1);
      chk("disp", display_digits, 16'h0000);
      @(posedge ref_clk);
      reg_monitor <= 1'b1;
      reg_addr_bcd <= 16'h0123;
      reg_data_bcd <= 16'h4567;
      wt(3);
      chk("reg", reg_lamp, 1'b1);
      chk("disp", display_digits, 16'h0123);
      key(4'hf);
      wt(2);
      chk("data", data_lamp, 1'b1);
      chk("disp", display_digits, 16'h4567);
      key(4'hf);
      wt(2);
      chk("reg", reg_lamp, 1'b1);
      @(posedge ref_clk);
      reg_monitor <= 1'b0;
      sc();
      selector <= 3'b001;
      sc();
      wt(1);
      chk("solving", solving, 1'b1);
      chk("outputs", outputs_enabled, 1'b1);
      lamps(1'b1);
      q.push_back({1'b1, 4'h0});
      key(4'hd);
      q.push_back({1'b1, 4'h0});
      key(4'h3);
      gap <= 4'hf;
      sc();
      selector <= 3'b100;
      wt(3);
      chk("tape", tape_route, 1'b0);
      sc();
      wt(1);
      chk("tape", tape_route, 1'b1);
      chk("solving", solving, 1'b0);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      programmer_present <= 1'b0;
      selector <= 3'b010;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      wt(1);
      chk("solving", solving, 1'b1);
      wt(4);
      chk("queue", 16'(q.size()), 16'h0);
      summarize();
   end
endmodule
`default_nettype wire
